// ### hw/led_boost_fault_supervisor.sv
/*
 * Digital supervisor of an LED boost converter controller: enable pin
 * for dimming and sleep, oscillator selection and phased clock output,
 * start-up fault blanking, fault latching, open-LED retry, gate disable
 * and encoding of the two open-drain fault flags.
 * Assumes comparator outputs and pins arrive asynchronously and that an
 * outside host drives enable and pulls the flags up.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - enable low beyond the disable time shuts all down into sleep.
// - disable time is 32768 oscillator periods, counted on ticks.
// - LED current target is full with enable high, about 8% with it low.
// - oscillator pin tied off selects the internal 350 kHz setting.
// - phased clock output repeats the oscillator with a phase lag.
// - any fault releases its flags until removed; none pulls both low.
// - regulator undervoltage drops gate, releases both flags, unlatched.
// - after undervoltage, gate stays off and flags stay released until turn-on threshold.
// - string and output shorts latch gate off; clear by sleep or power.
// - open-LED fault latches, cleared by timeout, by enable low once open is gone, or by power cycle.
// - open-LED detection drops gate at once, releases general flag.
// - open-LED holds until timeout, retries gate, repeats while open.
// - undercurrent releases the general flag while driving, unlatched.
// - overtemperature releases general flag until recovery, no limiting.
// - fault detection waits for the blanking period after start-up.
// - open-LED detection is not blanked at start-up.
// - single shorted LED releases the general flag only while present.
// - string or output short holds gate low, releases the critical flag.
// - critical flag held low externally overrides the short disable.
// - general flag held low externally overrides the open-LED disable.
module led_boost_fault_supervisor #(
   parameter logic [15:0] DISABLE_PERIODS = led_sup_pkg::DISABLE_PERIODS
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic enable_i,
   input  wire logic oscillator_pin_clk_i,
   input  wire logic oscillator_pin_tied_i,
   input  wire logic internal_regulator_uv_i,
   input  wire logic internal_regulator_on_i,
   input  wire logic output_short_i,
   input  wire logic string_short_i,
   input  wire logic open_led_i,
   input  wire logic led_undercurrent_i,
   input  wire logic overtemp_i,
   input  wire logic temp_recovered_i,
   input  wire logic led_short_i,
   input  wire logic critical_fault_flag_i,
   output logic      critical_fault_flag_o,
   output logic      critical_fault_flag_oe_n_o,
   input  wire logic general_fault_flag_i,
   output logic      general_fault_flag_o,
   output logic      general_fault_flag_oe_n_o,
   output logic      gate_drive_out_o,
   output logic      phased_clock_out_o,
   output logic      current_level_full_o,
   output logic      sleep_o,
   output logic      osc_internal_sel_o
);

   localparam int          PHASE_CYC = led_sup_pkg::PHASE_DELAY_CYC;
   localparam logic [15:0] DIS_LAST  = DISABLE_PERIODS - 16'h0001;
   localparam logic [15:0] BLANK_LAST =
      led_sup_pkg::FAULT_BLANK_PERIODS - 16'h0001;
   localparam logic [15:0] OPEN_LAST =
      led_sup_pkg::OPEN_TIMEOUT_PERIODS - 16'h0001;

   led_sup_pkg::sup_state_type  state;
   led_sup_pkg::sup_state_type  next_state;
   led_sup_pkg::open_state_type open_st;
   led_sup_pkg::open_state_type next_open_st;

   logic [13:0]          raw_in;
   logic [13:0]          sync_q;
   logic                 en_s;
   logic                 ext_clk_s;
   logic                 tied_s;
   logic                 crit_pin_s;
   logic                 gen_pin_s;
   logic                 uv_s;
   logic                 reg_on_s;
   logic                 oshort_s;
   logic                 sshort_s;
   logic                 open_s;
   logic                 ucur_s;
   logic                 otemp_s;
   logic                 trec_s;
   logic                 lshort_s;
   logic [5:0]           int_cnt;
   logic                 int_level;
   logic                 osc_sel_level;
   logic                 osc_level;
   logic                 osc_tick;
   logic [PHASE_CYC-1:0] ph_line;
   logic                 phased;
   logic [15:0]          dis_cnt;
   logic                 sleep_go;
   logic [15:0]          blank_cnt;
   logic                 blank_done;
   logic [15:0]          open_cnt;
   logic                 open_done;
   logic                 awake;
   logic                 run;
   logic                 uvlo;
   logic                 short_seen;
   logic                 short_lat;
   logic                 next_short_lat;
   logic                 ot_state;
   logic                 next_ot_state;
   logic                 open_active;
   logic                 crit_rel;
   logic                 gen_rel;
   logic                 next_crit_rel;
   logic                 next_gen_rel;
   logic [3:0]           crit_hist;
   logic [3:0]           gen_hist;
   logic                 crit_ovr;
   logic                 gen_ovr;
   logic                 short_kill;
   logic                 open_kill;
   logic                 gate;
   logic                 next_gate;
   logic                 level_full;

   // pins and comparator outputs are asynchronous to the reference clock
   assign raw_in = {enable_i, oscillator_pin_clk_i, oscillator_pin_tied_i,
                    critical_fault_flag_i, general_fault_flag_i,
                    internal_regulator_uv_i, internal_regulator_on_i,
                    output_short_i, string_short_i, open_led_i,
                    led_undercurrent_i, overtemp_i, temp_recovered_i,
                    led_short_i};

   pin_sync #(
      .WIDTH     (14),
      .RESET_VAL (led_sup_pkg::SYNC_RESET)
   ) pin_sync_inst (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (raw_in),
      .stable_o  (sync_q)
   );

   assign {en_s, ext_clk_s, tied_s, crit_pin_s, gen_pin_s, uv_s, reg_on_s,
           oshort_s, sshort_s, open_s, ucur_s, otemp_s, trec_s,
           lshort_s} = sync_q;

   // internal oscillator setting, free running divider
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || int_cnt == led_sup_pkg::INT_OSC_LAST) begin
         int_cnt <= 6'h00;
      end else begin
         int_cnt <= int_cnt + 6'h01;
      end
   end

   // tied-off pin picks the internal setting, else the pin clock
   assign int_level     = (int_cnt < led_sup_pkg::INT_OSC_HALF);
   assign osc_sel_level = tied_s ? int_level : ext_clk_s;
   assign osc_tick      = osc_sel_level & ~osc_level;

   // delay line gives a fixed lag; a slow external clock gets less
   // than a half-period shift, a limitation accepted for simplicity
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         osc_level <= 1'b0;
         ph_line   <= '0;
         phased    <= 1'b0;
      end else begin
         osc_level <= osc_sel_level;
         ph_line   <= {ph_line[PHASE_CYC-2:0], osc_level};
         phased    <= ph_line[PHASE_CYC-1] & awake;
      end
   end

   // enable-low timer in oscillator periods
   assign sleep_go = ~en_s & osc_tick & (dis_cnt == DIS_LAST) &
                     (state != led_sup_pkg::ST_SLEEP);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || en_s) begin
         dis_cnt <= 16'h0000;
      end else if (osc_tick && dis_cnt != DIS_LAST) begin
         dis_cnt <= dis_cnt + 16'h0001;
      end
   end

   // start-up blanking timer, restarted on every entry to blanking
   assign blank_done = osc_tick & (blank_cnt == BLANK_LAST);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || state != led_sup_pkg::ST_BLANK) begin
         blank_cnt <= 16'h0000;
      end else if (osc_tick) begin
         blank_cnt <= blank_cnt + 16'h0001;
      end
   end

   // power sequencing: undervoltage lockout, blanking, run, sleep
   always_comb begin
      next_state = state;
      case (state)
         led_sup_pkg::ST_UVLO: begin
            if (sleep_go) begin
               next_state = led_sup_pkg::ST_SLEEP;
            end else if (reg_on_s && !uv_s) begin
               next_state = led_sup_pkg::ST_BLANK;
            end
         end
         led_sup_pkg::ST_BLANK: begin
            if (sleep_go) begin
               next_state = led_sup_pkg::ST_SLEEP;
            end else if (uv_s) begin
               next_state = led_sup_pkg::ST_UVLO;
            end else if (blank_done) begin
               next_state = led_sup_pkg::ST_RUN;
            end
         end
         led_sup_pkg::ST_RUN: begin
            if (sleep_go) begin
               next_state = led_sup_pkg::ST_SLEEP;
            end else if (uv_s) begin
               next_state = led_sup_pkg::ST_UVLO;
            end
         end
         led_sup_pkg::ST_SLEEP: begin
            if (en_s) begin
               next_state = led_sup_pkg::ST_BLANK;
            end
         end
         default: begin
            next_state = led_sup_pkg::ST_UVLO;
         end
      endcase
   end

   assign awake = (state != led_sup_pkg::ST_SLEEP);
   assign run   = (state == led_sup_pkg::ST_RUN);
   assign uvlo  = (state == led_sup_pkg::ST_UVLO);

   // short latch: set only after blanking, cleared only by sleep
   assign short_seen = run & (oshort_s | sshort_s);
   assign next_short_lat = short_seen |
                           (short_lat & (state != led_sup_pkg::ST_SLEEP));

   // overtemperature holds until the recovery comparator reports cool
   assign next_ot_state = (run & otemp_s) |
                          (ot_state & run & ~trec_s);

   // open-LED retry: hold off for the timeout, then let the gate try again
   assign open_done = osc_tick & (open_cnt == OPEN_LAST);

   always_comb begin
      next_open_st = open_st;
      case (open_st)
         led_sup_pkg::OPEN_CLEAR: begin
            // no blanking here: open is acted on at once
            if (awake && !uvlo && open_s) begin
               next_open_st = led_sup_pkg::OPEN_HOLD;
            end
         end
         led_sup_pkg::OPEN_HOLD: begin
            if (!awake || uvlo) begin
               next_open_st = led_sup_pkg::OPEN_CLEAR;
            end else if (!en_s && !open_s) begin
               next_open_st = led_sup_pkg::OPEN_CLEAR;
            end else if (open_done) begin
               next_open_st = led_sup_pkg::OPEN_CLEAR;
            end
         end
         default: begin
            next_open_st = led_sup_pkg::OPEN_CLEAR;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || open_st != led_sup_pkg::OPEN_HOLD) begin
         open_cnt <= 16'h0000;
      end else if (osc_tick) begin
         open_cnt <= open_cnt + 16'h0001;
      end
   end

   assign open_active = (open_st == led_sup_pkg::OPEN_HOLD) |
                        (awake & ~uvlo & open_s);

   // flag encoding: released while any mapped fault is active
   assign next_crit_rel = uvlo | short_lat | short_seen;
   assign next_gen_rel  = uvlo | open_active | ot_state |
                          (run & (ucur_s | lshort_s));

   // override needs the flag released for a while, so the stale low
   // readback through the synchroniser cannot fake a pull-down
   assign crit_ovr = (&crit_hist) & ~crit_pin_s;
   assign gen_ovr  = (&gen_hist) & ~gen_pin_s;

   assign short_kill = (short_lat | short_seen) & ~crit_ovr;
   assign open_kill  = open_active & ~gen_ovr;
   assign next_gate  = (state == led_sup_pkg::ST_RUN ||
                        state == led_sup_pkg::ST_BLANK) &
                       ~short_kill & ~open_kill & ~sleep_go;

   // state and output registers
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state      <= led_sup_pkg::ST_UVLO;
         open_st    <= led_sup_pkg::OPEN_CLEAR;
         short_lat  <= 1'b0;
         ot_state   <= 1'b0;
         crit_rel   <= 1'b0;
         gen_rel    <= 1'b0;
         crit_hist  <= 4'h0;
         gen_hist   <= 4'h0;
         gate       <= 1'b0;
         level_full <= 1'b0;
      end else begin
         state      <= next_state;
         open_st    <= next_open_st;
         short_lat  <= next_short_lat;
         ot_state   <= next_ot_state;
         crit_rel   <= next_crit_rel;
         gen_rel    <= next_gen_rel;
         crit_hist  <= {crit_hist[2:0], crit_rel};
         gen_hist   <= {gen_hist[2:0], gen_rel};
         gate       <= next_gate;
         level_full <= en_s & awake;
      end
   end

   // open-drain flags: pull-down enabled only when no fault
   assign critical_fault_flag_o      = 1'b0;
   assign critical_fault_flag_oe_n_o = crit_rel;
   assign general_fault_flag_o       = 1'b0;
   assign general_fault_flag_oe_n_o  = gen_rel;

   assign gate_drive_out_o     = gate;
   assign phased_clock_out_o   = phased;
   assign current_level_full_o = level_full;
   assign sleep_o              = ~awake;
   assign osc_internal_sel_o   = tied_s;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   chk_sleep_entry: assert property (
      sleep_go |=> sleep_o && !gate_drive_out_o ##1 !gate_drive_out_o)
      else $error("sleep not entered after disable time");

   chk_disable_count: assert property (
      $rose(sleep_o) |-> $past(dis_cnt) == DIS_LAST && !$past(en_s))
      else $error("sleep entered before full disable count");

   chk_level_follow: assert property (
      !sleep_o && $stable(en_s) |=> current_level_full_o == $past(en_s))
      else $error("current level does not follow enable");

   chk_internal_osc: assert property (
      tied_s && $past(tied_s) |->
         osc_internal_sel_o && (osc_tick == (int_cnt == 6'h00)))
      else $error("internal oscillator not selected");

   chk_phase_lag: assert property (
      $past(awake) && !$past(rst_i, PHASE_CYC+1) |->
         phased_clock_out_o == $past(osc_level, PHASE_CYC+1))
      else $error("phased clock lag wrong");

   chk_flags_idle: assert property (
      !next_crit_rel && !next_gen_rel |=>
         !critical_fault_flag_oe_n_o && !general_fault_flag_oe_n_o)
      else $error("flag released with no fault");

   chk_uv_gate: assert property (
      awake && uv_s && !sleep_go |=> ##1 !gate_drive_out_o &&
         critical_fault_flag_oe_n_o && general_fault_flag_oe_n_o)
      else $error("undervoltage did not disable and release flags");

   chk_uv_hold: assert property (
      uvlo && !reg_on_s |=> !gate_drive_out_o)
      else $error("outputs active below turn-on threshold");

   chk_short_latch: assert property (
      short_lat && awake && !sleep_go && !crit_ovr |=>
         short_lat && !gate_drive_out_o)
      else $error("short fault not held latched");

   chk_open_gate: assert property (
      awake && !uvlo && open_s && open_st == led_sup_pkg::OPEN_CLEAR |=>
         !gate_drive_out_o && general_fault_flag_oe_n_o)
      else $error("open LED did not drop gate");

   chk_open_retry: assert property (
      open_st == led_sup_pkg::OPEN_HOLD && awake && !uvlo && open_done |=>
         open_st == led_sup_pkg::OPEN_CLEAR)
      else $error("open LED hold did not end at timeout");

   chk_blank_short: assert property (
      $rose(short_lat) |-> $past(state) == led_sup_pkg::ST_RUN)
      else $error("short latched during blanking");

endmodule // led_boost_fault_supervisor

`default_nettype wire

// ### hw/led_sup_pkg.sv
/*
 * Shared constants and state types of the LED boost fault supervisor:
 * reference clock rate, internal oscillator divider, phase delay of the
 * chained clock output, and the oscillator-period timer lengths.
 * Assumes the supervisor runs from one 20 MHz reference clock.
 */
`default_nettype none

package led_sup_pkg;

   // reference clock
   localparam int unsigned REF_CLK_HZ    = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS = 50;

   // internal oscillator setting, made by dividing the reference clock
   localparam int unsigned INT_OSC_HZ   = 350_000;
   localparam int unsigned INT_OSC_DIV  = REF_CLK_HZ / INT_OSC_HZ;
   localparam logic [5:0]  INT_OSC_LAST = 6'(INT_OSC_DIV - 1);
   localparam logic [5:0]  INT_OSC_HALF = 6'(INT_OSC_DIV / 2);

   // phase lag of the chained clock output behind the oscillator
   localparam int unsigned PHASE_DELAY_NS  = 700;
   localparam int unsigned PHASE_DELAY_CYC = PHASE_DELAY_NS / CLK_PERIOD_NS;

   // timers counted in oscillator periods, so they scale with the oscillator
   localparam logic [15:0] DISABLE_PERIODS      = 16'h8000;
   localparam logic [15:0] FAULT_BLANK_PERIODS  = 16'h0400;
   localparam logic [15:0] OPEN_TIMEOUT_PERIODS = 16'h0800;

   // reset values
   localparam logic [13:0] SYNC_RESET = 14'h0000;

   typedef enum logic [1:0] {
      ST_UVLO,
      ST_BLANK,
      ST_RUN,
      ST_SLEEP
   } sup_state_type;

   typedef enum logic {
      OPEN_CLEAR,
      OPEN_HOLD
   } open_state_type;

endpackage

`default_nettype wire

// ### hw/pin_sync.sv
/*
 * Three-stage input synchroniser bank with agreement filter.
 * Each bit passes three flip-flops; the output takes a new value only
 * once the second and third stages agree. Inputs are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int          WIDTH     = 1,
   parameter logic [13:0] RESET_VAL = led_sup_pkg::SYNC_RESET
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] stable_o
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         logic st;

         // s1 feeds s2 only; the agreement check looks at s2 and s3
         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               s1 <= RESET_VAL[g];
               s2 <= RESET_VAL[g];
               s3 <= RESET_VAL[g];
               st <= RESET_VAL[g];
            end else begin
               s1 <= async_i[g];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) begin
                  st <= s3;
               end
            end
         end

         assign stable_o[g] = st;
      end
   endgenerate

endmodule // pin_sync

`default_nettype wire

// ### tb/host_model.sv
/*
 * host model: passes the enable command, makes an external oscillator
 * clock and pulls both open-drain fault flags up.
 * assumes flag oe_n high means the supervisor has released the flag.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic ref_clk_i,
   input  wire logic en_cmd_i,
   input  wire logic hold_crit_i,
   input  wire logic hold_gen_i,
   input  wire logic crit_oe_n_i,
   input  wire logic gen_oe_n_i,
   output logic      enable_o,
   output logic      osc_clk_o,
   output logic      crit_wire_o,
   output logic      gen_wire_o
);
   logic [2:0] div = 3'h0;
   // dimming pulses stay far below the disable time
   assign enable_o = en_cmd_i;
   // 8-clock period, 4 high 4 low, so the syncs always see it
   always @(negedge ref_clk_i) begin
      div <= div + 3'h1;
   end
   assign osc_clk_o = div[2];
   // pull-up unless the host holds a released flag low
   assign crit_wire_o = crit_oe_n_i & ~hold_crit_i;
   assign gen_wire_o  = gen_oe_n_i & ~hold_gen_i;
endmodule // host_model
`default_nettype wire

// ### tb/tb_led_boost_fault_supervisor.sv
/*
 * bench of the LED boost fault supervisor beside a host model.
 * assumes a 20 MHz clock and a disable time shortened to 16 ticks.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; \
   if ((got) !== (ex)) begin num_errors++; \
   $display("unexpected %s exp %b got %b", nm, ex, got); end end
module tb_led_boost_fault_supervisor;
   localparam logic [15:0] DIS = 16'h0010;
   localparam int TICK  = 8;
   localparam int BLANK = 1024 * TICK + 40;
   int num_errors  = 0;
   int check_count = 0;
   int cyc         = 0;
   int n;
   logic ref_clk_i = 1'h0, rst_i = 1'h1, en_cmd = 1'h1;
   logic hold_crit = 1'h0, hold_gen = 1'h0;
   logic oscillator_pin_tied_i = 1'h1, temp_recovered_i = 1'h1;
   logic internal_regulator_uv_i = 1'h1, internal_regulator_on_i = 1'h0;
   logic output_short_i = 1'h0, string_short_i = 1'h0, open_led_i = 1'h0;
   logic led_undercurrent_i = 1'h0, overtemp_i = 1'h0, led_short_i = 1'h0;
   logic enable_i, oscillator_pin_clk_i;
   logic critical_fault_flag_i, general_fault_flag_i;
   logic critical_fault_flag_o, critical_fault_flag_oe_n_o;
   logic general_fault_flag_o, general_fault_flag_oe_n_o;
   logic gate_drive_out_o, phased_clock_out_o, current_level_full_o;
   logic sleep_o, osc_internal_sel_o;

   always #25 ref_clk_i = ~ref_clk_i;

   led_boost_fault_supervisor #(.DISABLE_PERIODS(DIS))
   led_boost_fault_supervisor_inst (.ref_clk_i, .rst_i, .enable_i,
      .oscillator_pin_clk_i, .oscillator_pin_tied_i,
      .internal_regulator_uv_i, .internal_regulator_on_i,
      .output_short_i, .string_short_i, .open_led_i, .led_undercurrent_i,
      .overtemp_i, .temp_recovered_i, .led_short_i, .critical_fault_flag_i,
      .critical_fault_flag_o, .critical_fault_flag_oe_n_o,
      .general_fault_flag_i, .general_fault_flag_o,
      .general_fault_flag_oe_n_o, .gate_drive_out_o, .phased_clock_out_o,
      .current_level_full_o, .sleep_o, .osc_internal_sel_o);

   host_model host_model_inst (.ref_clk_i, .en_cmd_i(en_cmd),
      .hold_crit_i(hold_crit), .hold_gen_i(hold_gen),
      .crit_oe_n_i(critical_fault_flag_oe_n_o),
      .gen_oe_n_i(general_fault_flag_oe_n_o), .enable_o(enable_i),
      .osc_clk_o(oscillator_pin_clk_i), .crit_wire_o(critical_fault_flag_i),
      .gen_wire_o(general_fault_flag_i));

   task automatic wt(input int c);
      repeat (c) @(negedge ref_clk_i);
   endtask

   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // lockout until the turn-on threshold, then blanking with gate allowed
   task automatic t_uvlo();
      wt(10);
      `CHK("gate_uv", 1'h0, gate_drive_out_o)
      `CHK("crit_uv", 1'h1, critical_fault_flag_oe_n_o)
      `CHK("gen_uv", 1'h1, general_fault_flag_oe_n_o)
      internal_regulator_uv_i = 1'h0;
      wt(10);
      `CHK("gate_hyst", 1'h0, gate_drive_out_o)
      internal_regulator_on_i = 1'h1;
      wt(10);
      `CHK("gate_on", 1'h1, gate_drive_out_o)
      `CHK("crit_ok", 1'h0, critical_fault_flag_oe_n_o)
      `CHK("gen_ok", 1'h0, general_fault_flag_oe_n_o)
      `CHK("crit_lvl", 1'h0, critical_fault_flag_o)
      `CHK("gen_lvl", 1'h0, general_fault_flag_o)
   endtask

   // undervoltage in run: gate off, flags out until turn-on passes
   task automatic t_uvrun();
      internal_regulator_uv_i = 1'h1;
      internal_regulator_on_i = 1'h0;
      wt(10);
      `CHK("gate_uvr", 1'h0, gate_drive_out_o)
      `CHK("crit_uvr", 1'h1, critical_fault_flag_oe_n_o)
      `CHK("gen_uvr", 1'h1, general_fault_flag_oe_n_o)
      internal_regulator_uv_i = 1'h0;
      wt(10);
      `CHK("gate_uvh", 1'h0, gate_drive_out_o)
      internal_regulator_on_i = 1'h1;
      wt(10);
      `CHK("gate_uvb", 1'h1, gate_drive_out_o)
      `CHK("crit_uvb", 1'h0, critical_fault_flag_oe_n_o)
   endtask

   // faults blanked, open LED not; open latch cleared by enable low
   task automatic t_blank();
      led_undercurrent_i = 1'h1;
      wt(10);
      `CHK("gen_blank", 1'h0, general_fault_flag_oe_n_o)
      led_undercurrent_i = 1'h0;
      open_led_i = 1'h1;
      wt(6);
      `CHK("gate_open", 1'h0, gate_drive_out_o)
      `CHK("gen_open", 1'h1, general_fault_flag_oe_n_o)
      open_led_i = 1'h0;
      wt(10);
      `CHK("open_latch", 1'h0, gate_drive_out_o)
      en_cmd = 1'h0;
      wt(10);
      en_cmd = 1'h1;
      wt(10);
      `CHK("open_clear", 1'h1, gate_drive_out_o)
      `CHK("gen_clear", 1'h0, general_fault_flag_oe_n_o)
      n = 0;
      for (int i = 0; i < 80; i++) begin
         wt(1);
         n += int'(phased_clock_out_o === 1'h1);
      end
      `CHK("phased", 1'h1, 1'(n > 20 && n < 60))
      wt(BLANK);
   endtask

   // unlatched general-flag faults; overtemp waits for recovery
   task automatic t_flags();
      for (int i = 0; i < 3; i++) begin
         temp_recovered_i = 1'h0;
         {led_undercurrent_i, overtemp_i, led_short_i} = 3'h1 << i;
         wt(10);
         `CHK("gen_set", 1'h1, general_fault_flag_oe_n_o)
         `CHK("gate_run", 1'h1, gate_drive_out_o)
         `CHK("crit_set", 1'h0, critical_fault_flag_oe_n_o)
         {led_undercurrent_i, overtemp_i, led_short_i} = 3'h0;
         wt(10);
         `CHK("gen_hold", 1'(i == 1), general_fault_flag_oe_n_o)
         temp_recovered_i = 1'h1;
         wt(10);
         `CHK("gen_gone", 1'h0, general_fault_flag_oe_n_o)
      end
   endtask

   // dimming pulses switch the current target without sleeping
   task automatic t_dim();
      for (int i = 0; i < 3; i++) begin
         en_cmd = 1'h0;
         wt(40);
         `CHK("level_lo", 1'h0, current_level_full_o)
         `CHK("no_sleep", 1'h0, sleep_o)
         en_cmd = 1'h1;
         wt(40);
         `CHK("level_hi", 1'h1, current_level_full_o)
      end
   endtask

   // output then string short: latch, override, cleared only by sleep
   task automatic t_short();
      for (int k = 0; k < 2; k++) begin
         {output_short_i, string_short_i} = (k == 0) ? 2'h2 : 2'h1;
         wt(10);
         `CHK("crit_sh", 1'h1, critical_fault_flag_oe_n_o)
         `CHK("gen_sh", 1'h0, general_fault_flag_oe_n_o)
         `CHK("gate_sh", 1'h0, gate_drive_out_o)
         {output_short_i, string_short_i} = 2'h0;
         wt(10);
         `CHK("crit_lat", 1'h1, critical_fault_flag_oe_n_o)
         if (k == 0) begin
            hold_crit = 1'h1;
            wt(10);
            `CHK("gate_ovr", 1'h1, gate_drive_out_o)
            `CHK("crit_kept", 1'h1, critical_fault_flag_oe_n_o)
            hold_crit = 1'h0;
            wt(10);
         end
         `CHK("gate_lat", 1'h0, gate_drive_out_o)
         en_cmd = 1'h0;
         wt(100);
         `CHK("sleep_early", 1'h0, sleep_o)
         wt(100);
         `CHK("sleep", 1'h1, sleep_o)
         `CHK("ph_sleep", 1'h0, phased_clock_out_o)
         `CHK("crit_clr", 1'h0, critical_fault_flag_oe_n_o)
         en_cmd = 1'h1;
         wt(BLANK);
         `CHK("gate_back", 1'h1, gate_drive_out_o)
      end
   endtask

   // open LED: override, then hold until the timeout and retry
   task automatic t_open();
      open_led_i = 1'h1;
      wt(10);
      `CHK("gate_op", 1'h0, gate_drive_out_o)
      hold_gen = 1'h1;
      wt(10);
      `CHK("gate_ovr2", 1'h1, gate_drive_out_o)
      hold_gen = 1'h0;
      open_led_i = 1'h0;
      wt(2048 * TICK - 200);
      `CHK("gate_hold", 1'h0, gate_drive_out_o)
      wt(400);
      `CHK("gate_retry", 1'h1, gate_drive_out_o)
   endtask

   // hang guard, about 42k cycles are expected
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      wt(6);
      `CHK("crit_rst", 1'h0, critical_fault_flag_oe_n_o)
      `CHK("gate_rst", 1'h0, gate_drive_out_o)
      rst_i = 1'h0;
      wt(10);
      `CHK("osc_int", 1'h1, osc_internal_sel_o)
      oscillator_pin_tied_i = 1'h0;
      t_uvlo();
      `CHK("osc_ext", 1'h0, osc_internal_sel_o)
      t_blank();
      t_flags();
      t_dim();
      t_short();
      t_open();
      t_uvrun();
      summarize();
   end
endmodule // tb_led_boost_fault_supervisor
`default_nettype wire
